/* ddr_pin_defines.vh */
`ifndef DDR_PIN_DEFINES_VH
`define DDR_PIN_DEFINES_VH

// Command codes, first half of the command/address word
`define CMD_ACT      2'h2
`define CMD_WR       3'h1
`define CMD_RD       3'h5
`define CMD_MRW      4'h0
`define CMD_REFPB    4'h4
`define CMD_REFAB    4'hc
`define CMD_BST      4'h3
`define CMD_PRE      4'hb
`define CMD_NOP      4'h7

// Field positions
`define CA_AP_BIT    9
`define CA_PREALL    4
`define CA_MA_LO     4
`define CA_BANK_LO   0
`define CA_ROW_LO    2
`define CA_COL_LO    2

// Mode register addresses
`define MR_BURST     6'h01
`define MR_LAT       6'h02
`define MR_PARTIAL_ARRAY_SELF_REFRESH_BANK 6'h10
`define MR_PARTIAL_ARRAY_SELF_REFRESH_SEG  6'h11

// Burst length codes and beat counts
`define BL_CODE4     3'h2
`define BL_CODE8     3'h3
`define BL_CODE16    3'h4
`define BL_BEATS4    5'h04
`define BL_BEATS8    5'h08
`define BL_BEATS16   5'h10

// Power states
`define ST_ACTIVE    2'h0
`define ST_PDOWN     2'h1
`define ST_SREF      2'h2
`define ST_DPD       2'h3

// Reset values
`define RL_RST       4'h3
`define WL_RST       4'h1
`define PARTIAL_ARRAY_SELF_REFRESH_RST     4'h0

// Prefetch depth in beats
`define PF_DEPTH     5'h04

`endif

/* input_sync3.v */
`timescale 1ns/10ps
module input_sync3 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         reset,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  integer i;

  always @(posedge clk) begin
    if (reset) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts once stages two and three agree
      for (i = 0; i < W; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // input_sync3

/* ddr_sdram_pin_interface.v */
// Function
// R1: Command/address captured on both clock edges
// R2: Chip select, clock enable sampled rising only
// R3: Clock pair crossings define positive, negative edges
// R4: Clock enable low disables clocks, buffers, drivers
// R5: Command decoded from enable, select, address
// R6: Strobes driven by device with read data
// R7: Read strobe edge aligned; write strobe centred
// R8: Data bus width sixteen or thirty-two
// R9: Strobe pairs 0,1 qualify bytes 0,1
// R10: Burst lengths of 4, 8, 16
// R11: Programmable read and write latencies
// R12: Four-beat prefetch per internal access
// R13: All-bank refresh only; per-bank ignored
// R14: Precharge one bank or all banks
// R15: Self-refresh bank mask; segment mask ignored
// R16: Data mask blocks selected write bytes
// R17: Stopped clock tolerated while idle
// R18: Deep power-down distinct from self refresh
// R19: One command per clock cycle, two halves
// R20: Strobe pairs 2,3 qualify bytes 2,3
// R21: Masked bytes dropped, mask sampled both edges
// R22: Lowest column bit implied zero
`timescale 1ns/10ps
`include "ddr_pin_defines.vh"
module ddr_sdram_pin_interface #(
  parameter DQ_W  = 16,
  parameter LANES = DQ_W / 8,
  parameter ROW_W = 2,
  parameter COL_W = 6
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             ck_t,
  input  wire             ck_c,
  input  wire             cke,
  input  wire             cs_n,
  input  wire [9:0]       ca,
  input  wire [DQ_W-1:0]  dq_i,
  output reg  [DQ_W-1:0]  dq_o,
  output reg              dq_oe,
  input  wire [LANES-1:0] dqs_t_i,
  input  wire [LANES-1:0] dqs_c_i,
  output reg  [LANES-1:0] dqs_t_o,
  output reg  [LANES-1:0] dqs_c_o,
  output reg              dqs_oe,
  input  wire [LANES-1:0] dm_i,
  output reg  [1:0]       power_state,
  output wire             deep_power_down,
  output reg  [3:0]       bank_open,
  output reg  [3:0]       read_latency_cycles,
  output reg  [3:0]       write_latency_cycles,
  output reg  [4:0]       burst_beat_count,
  output reg  [3:0]       partial_array_self_refresh,
  output reg              cmd_strobe,
  output reg              refresh_pulse
);
  localparam SW = 14 + DQ_W + 3 * LANES;
  localparam AW = 2 + ROW_W + COL_W;

  function [AW-1:0] mem_idx;
    input [1:0]       b;
    input [ROW_W-1:0] r;
    input [COL_W-1:0] c;
    begin
      mem_idx = {b, r, c};
    end
  endfunction

  function [COL_W-1:0] col_at;
    input [COL_W-1:0] base;
    input [4:0]       off;
    begin
      col_at = base + {{(COL_W-5){1'b0}}, off};
    end
  endfunction

  // Synchronised pins
  wire [SW-1:0]    sy;
  wire             s_ckt;
  wire             s_ckc;
  wire             s_cke;
  wire             s_csn;
  wire [9:0]       s_ca;
  wire [DQ_W-1:0]  s_dq;
  wire [LANES-1:0] s_dqst;
  wire [LANES-1:0] s_dqsc;
  wire [LANES-1:0] s_dm;

  input_sync3 #(.W(SW)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({ck_t, ck_c, cke, cs_n, ca, dq_i, dqs_t_i, dqs_c_i, dm_i}),
    .q     (sy)
  );
  assign {s_ckt, s_ckc, s_cke, s_csn, s_ca, s_dq, s_dqst, s_dqsc, s_dm} = sy;

  // Differential clock edges at the crosspoints
  reg  ck_lvl_q;
  wire ck_lvl_d = (s_ckt & ~s_ckc) ? 1'b1 : (~s_ckt & s_ckc) ? 1'b0 : ck_lvl_q; // R3
  wire ck_pos   = ck_lvl_d & ~ck_lvl_q; // R3
  wire ck_neg   = ~ck_lvl_d & ck_lvl_q; // R3
  wire ck_edge  = ck_pos | ck_neg;

  reg       cke_q;
  reg       csn_q;
  reg [9:0] ca_pos_q;

  always @(posedge clk) begin
    if (reset) begin
      ck_lvl_q <= 1'b0;
      cke_q    <= 1'b0;
      csn_q    <= 1'b1;
      ca_pos_q <= 10'h000;
    end else begin
      ck_lvl_q <= ck_lvl_d;
      if (ck_pos) begin
        cke_q    <= s_cke; // R2
        csn_q    <= s_csn; // R2
        ca_pos_q <= s_ca; // R1
      end
    end
  end

  // Command completes with its second half at the negative edge
  wire             active = (power_state == `ST_ACTIVE);
  wire             cmd_ok = ck_neg & active & cke_q & ~csn_q; // R5 R19
  wire [3:0]       c4     = ca_pos_q[3:0];
  wire             is_act = (ca_pos_q[1:0] == `CMD_ACT);
  wire             is_wr  = (ca_pos_q[2:0] == `CMD_WR);
  wire             is_rd  = (ca_pos_q[2:0] == `CMD_RD);
  wire             is_mrw = (c4 == `CMD_MRW);
  wire             is_pre = (c4 == `CMD_PRE);
  wire             is_bst = (c4 == `CMD_BST);
  wire             is_ref = (c4 == `CMD_REFAB);
  wire [1:0]       n_bank = s_ca[`CA_BANK_LO +: 2]; // R1
  wire [ROW_W-1:0] n_row  = s_ca[`CA_ROW_LO +: ROW_W];
  wire [COL_W-1:0] n_col  = {s_ca[`CA_COL_LO +: COL_W-1], 1'b0}; // R22
  wire [5:0]       n_ma   = ca_pos_q[`CA_MA_LO +: 6];
  wire [7:0]       n_op   = s_ca[7:0];
  wire             n_open = bank_open[n_bank];

  reg [ROW_W-1:0] row_q [0:3];
  wire            rd_close;
  wire            wr_close;
  reg  [1:0]      rd_bank_q;
  reg  [1:0]      wr_bank_q;
  reg             rd_on_q;
  reg             wr_on_q;
  reg  [3:0]      rd_lat_q;
  reg  [3:0]      wr_lat_q;
  wire            busy = rd_on_q | wr_on_q | (rd_lat_q != 4'h0) | (wr_lat_q != 4'h0);
  integer         b;

  assign deep_power_down = (power_state == `ST_DPD); // R18

  // Power states, banks and mode settings
  always @(posedge clk) begin
    if (reset) begin
      power_state                <= `ST_ACTIVE;
      bank_open                  <= 4'h0;
      read_latency_cycles        <= `RL_RST;
      write_latency_cycles       <= `WL_RST;
      burst_beat_count           <= `BL_BEATS4;
      partial_array_self_refresh <= `PARTIAL_ARRAY_SELF_REFRESH_RST;
      cmd_strobe                 <= 1'b0;
      refresh_pulse              <= 1'b0;
      for (b = 0; b < 4; b = b + 1) begin
        row_q[b] <= {ROW_W{1'b0}};
      end
    end else begin
      cmd_strobe    <= cmd_ok;
      refresh_pulse <= 1'b0;
      if (ck_pos && cke_q && !s_cke) begin
        // Entry kind taken from the first half seen with the falling enable
        if (!s_csn && s_ca[3:0] == `CMD_REFAB && bank_open == 4'h0 && !busy) begin
          power_state <= `ST_SREF; // R4
        end else if (!s_csn && s_ca[3:0] == `CMD_BST && bank_open == 4'h0) begin
          power_state <= `ST_DPD; // R18
        end else begin
          power_state <= `ST_PDOWN; // R4
        end
      end else if (ck_pos && !cke_q && s_cke) begin
        power_state <= `ST_ACTIVE; // R4
        if (power_state == `ST_DPD) begin
          // Settings do not survive deep power-down
          read_latency_cycles        <= `RL_RST; // R18
          write_latency_cycles       <= `WL_RST;
          burst_beat_count           <= `BL_BEATS4;
          partial_array_self_refresh <= `PARTIAL_ARRAY_SELF_REFRESH_RST;
          bank_open                  <= 4'h0;
        end
      end else if (cmd_ok) begin
        if (is_act) begin
          bank_open[n_bank] <= 1'b1;
          row_q[n_bank]     <= n_row;
        end else if (is_pre) begin
          if (ca_pos_q[`CA_PREALL]) begin
            bank_open <= 4'h0; // R14
          end else begin
            bank_open[n_bank] <= 1'b0; // R14
          end
        end else if (is_ref && bank_open == 4'h0) begin
          refresh_pulse <= 1'b1; // R13
        end else if (is_mrw) begin
          case (n_ma)
            `MR_BURST: begin
              case (n_op[2:0])
                `BL_CODE4:  burst_beat_count <= `BL_BEATS4; // R10
                `BL_CODE8:  burst_beat_count <= `BL_BEATS8; // R10
                `BL_CODE16: burst_beat_count <= `BL_BEATS16; // R10
                default:    burst_beat_count <= burst_beat_count;
              endcase
            end
            `MR_LAT: begin
              if (n_op[3:0] != 4'h0) begin
                read_latency_cycles <= n_op[3:0]; // R11
              end
              if (n_op[7:4] != 4'h0) begin
                write_latency_cycles <= n_op[7:4]; // R11
              end
            end
            `MR_PARTIAL_ARRAY_SELF_REFRESH_BANK: partial_array_self_refresh <= n_op[3:0]; // R15
            `MR_PARTIAL_ARRAY_SELF_REFRESH_SEG:  partial_array_self_refresh <= partial_array_self_refresh; // R15
            default:       partial_array_self_refresh <= partial_array_self_refresh;
          endcase
        end
      end else begin
        // Auto-precharge at the end of a burst
        if (rd_close) begin
          bank_open[rd_bank_q] <= 1'b0;
        end
        if (wr_close) begin
          bank_open[wr_bank_q] <= 1'b0;
        end
      end
    end
  end

  reg [DQ_W-1:0] mem [0:(1<<AW)-1];

  // Read engine with four-beat prefetch
  reg  [DQ_W-1:0]  pf_q [0:3];
  reg  [ROW_W-1:0] rd_row_q;
  reg  [COL_W-1:0] rd_col_q;
  reg  [4:0]       rd_beat_q;
  reg  [4:0]       rd_bl_q;
  reg              rd_ap_q;
  wire             rd_cmd   = cmd_ok & is_rd & n_open;
  wire             rd_start = ck_pos & active & (rd_lat_q == 4'h1); // R11
  wire             rd_step  = ck_edge & rd_on_q & (rd_beat_q != rd_bl_q); // R1
  wire             rd_end   = ck_edge & rd_on_q & (rd_beat_q == rd_bl_q);
  wire             rd_emit  = rd_start | rd_step;
  wire             pf_load  = rd_cmd | (rd_emit & (rd_beat_q[1:0] == 2'h3)); // R12
  wire [1:0]       pf_bank  = rd_cmd ? n_bank : rd_bank_q;
  wire [ROW_W-1:0] pf_row   = rd_cmd ? row_q[n_bank] : rd_row_q;
  wire [COL_W-1:0] pf_base  = rd_cmd ? n_col : rd_col_q;
  wire [4:0]       pf_off   = rd_cmd ? 5'h00 : rd_beat_q + 5'h01;
  reg  [4:0]       pi;
  assign rd_close = rd_end & rd_ap_q;

  always @(posedge clk) begin
    if (reset) begin
      rd_lat_q  <= 4'h0;
      rd_on_q   <= 1'b0;
      rd_beat_q <= 5'h00;
      rd_bl_q   <= `BL_BEATS4;
      rd_ap_q   <= 1'b0;
      rd_bank_q <= 2'h0;
      rd_row_q  <= {ROW_W{1'b0}};
      rd_col_q  <= {COL_W{1'b0}};
      dq_o      <= {DQ_W{1'b0}};
      dq_oe     <= 1'b0;
      dqs_t_o   <= {LANES{1'b0}};
      dqs_c_o   <= {LANES{1'b1}};
      dqs_oe    <= 1'b0;
      for (pi = 5'h00; pi < `PF_DEPTH; pi = pi + 5'h01) begin
        pf_q[pi[1:0]] <= {DQ_W{1'b0}};
      end
    end else if (!active || (cmd_ok && is_bst)) begin
      // Drivers off while clocks are gated or the burst is cut
      rd_lat_q <= 4'h0; // R4
      rd_on_q  <= 1'b0;
      dq_oe    <= 1'b0; // R4
      dqs_oe   <= 1'b0;
    end else begin
      if (pf_load) begin
        for (pi = 5'h00; pi < `PF_DEPTH; pi = pi + 5'h01) begin
          pf_q[pi[1:0]] <= mem[mem_idx(pf_bank, pf_row, col_at(pf_base, pf_off + pi))]; // R12
        end
      end
      if (rd_cmd) begin
        rd_lat_q  <= read_latency_cycles; // R11
        rd_on_q   <= 1'b0;
        rd_beat_q <= 5'h00;
        rd_bl_q   <= burst_beat_count; // R10
        rd_ap_q   <= ca_pos_q[`CA_AP_BIT];
        rd_bank_q <= n_bank;
        rd_row_q  <= row_q[n_bank];
        rd_col_q  <= n_col;
      end else if (ck_pos && rd_lat_q != 4'h0) begin
        rd_lat_q <= rd_lat_q - 4'h1;
      end
      if (rd_emit && !rd_cmd) begin
        rd_on_q   <= 1'b1;
        rd_beat_q <= rd_beat_q + 5'h01;
        dq_o      <= pf_q[rd_beat_q[1:0]];
        dq_oe     <= 1'b1;
        dqs_oe    <= 1'b1; // R6
        dqs_t_o   <= {LANES{~rd_beat_q[0]}}; // R7
        dqs_c_o   <= {LANES{rd_beat_q[0]}}; // R7
      end else if (rd_end) begin
        rd_on_q <= 1'b0;
        dq_oe   <= 1'b0;
        dqs_oe  <= 1'b0;
      end
    end
  end

  // Write engine: each strobe pair clocks its own byte lane
  reg  [LANES-1:0] dqs_lvl_q;
  reg  [LANES-1:0] dqs_lvl_d;
  reg  [LANES-1:0] lane_take;
  reg              lanes_done;
  reg  [4:0]       wr_cnt_q [0:LANES-1];
  reg  [ROW_W-1:0] wr_row_q;
  reg  [COL_W-1:0] wr_col_q;
  reg  [4:0]       wr_bl_q;
  reg              wr_ap_q;
  wire             wr_cmd  = cmd_ok & is_wr & n_open;
  wire             wr_end  = wr_on_q & lanes_done;
  integer          k;
  integer          kw;
  integer          ks;
  assign wr_close = wr_end & wr_ap_q;

  always @* begin
    lanes_done = 1'b1;
    for (k = 0; k < LANES; k = k + 1) begin
      if (s_dqst[k] & ~s_dqsc[k]) begin
        dqs_lvl_d[k] = 1'b1;
      end else if (~s_dqst[k] & s_dqsc[k]) begin
        dqs_lvl_d[k] = 1'b0;
      end else begin
        dqs_lvl_d[k] = dqs_lvl_q[k];
      end
      // Both strobe edges carry a beat
      lane_take[k] = wr_on_q & (dqs_lvl_d[k] ^ dqs_lvl_q[k]) & (wr_cnt_q[k] != wr_bl_q); // R7 R9 R20
      if (wr_cnt_q[k] != wr_bl_q) begin
        lanes_done = 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      dqs_lvl_q <= {LANES{1'b0}};
      wr_lat_q  <= 4'h0;
      wr_on_q   <= 1'b0;
      wr_bl_q   <= `BL_BEATS4;
      wr_ap_q   <= 1'b0;
      wr_bank_q <= 2'h0;
      wr_row_q  <= {ROW_W{1'b0}};
      wr_col_q  <= {COL_W{1'b0}};
      for (kw = 0; kw < LANES; kw = kw + 1) begin
        wr_cnt_q[kw] <= 5'h00;
      end
    end else begin
      dqs_lvl_q <= dqs_lvl_d;
      if (!active || (cmd_ok && is_bst)) begin
        wr_lat_q <= 4'h0; // R4
        wr_on_q  <= 1'b0;
      end else if (wr_cmd) begin
        wr_lat_q  <= write_latency_cycles; // R11
        wr_on_q   <= 1'b0;
        wr_bl_q   <= burst_beat_count; // R10
        wr_ap_q   <= ca_pos_q[`CA_AP_BIT];
        wr_bank_q <= n_bank;
        wr_row_q  <= row_q[n_bank];
        wr_col_q  <= n_col;
        for (kw = 0; kw < LANES; kw = kw + 1) begin
          wr_cnt_q[kw] <= 5'h00;
        end
      end else begin
        if (ck_pos && wr_lat_q != 4'h0) begin
          wr_lat_q <= wr_lat_q - 4'h1;
          if (wr_lat_q == 4'h1) begin
            wr_on_q <= 1'b1; // R11
          end
        end
        if (wr_end) begin
          wr_on_q <= 1'b0;
        end
        for (kw = 0; kw < LANES; kw = kw + 1) begin
          if (lane_take[kw]) begin
            wr_cnt_q[kw] <= wr_cnt_q[kw] + 5'h01;
          end
        end
      end
    end
  end

  // Array store; masked bytes leave their byte of the word untouched
  always @(posedge clk) begin
    if (active) begin
      for (ks = 0; ks < LANES; ks = ks + 1) begin
        if (lane_take[ks] && !s_dm[ks]) begin
          mem[mem_idx(wr_bank_q, wr_row_q, col_at(wr_col_q, wr_cnt_q[ks]))][ks*8 +: 8]
            <= s_dq[ks*8 +: 8]; // R16 R21 R8
        end
      end
    end
  end

  // Nothing here waits on the link clock while idle, so it may stop
  // without a timeout or state loss. R17
endmodule // ddr_sdram_pin_interface

/* ddr_pin_checker_assertions.sv */
`timescale 1ns/10ps
module ddr_pin_checker #(
  parameter DQ_W  = 16,
  parameter LANES = DQ_W / 8
) (
  input wire             clk,
  input wire             reset,
  input wire             dq_oe,
  input wire [LANES-1:0] dqs_t_o,
  input wire [LANES-1:0] dqs_c_o,
  input wire             dqs_oe,
  input wire [1:0]       power_state,
  input wire             deep_power_down,
  input wire [3:0]       bank_open,
  input wire [4:0]       burst_beat_count,
  input wire             cmd_strobe,
  input wire             refresh_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_oe_pair: assert property (dq_oe == dqs_oe)
    else $error("data and strobe enables differ");
  a_strobe_comp: assert property (dqs_oe |-> dqs_c_o == ~dqs_t_o)
    else $error("read strobe not complementary");
  a_lanes_same: assert property (dqs_oe |-> dqs_t_o == {LANES{dqs_t_o[0]}})
    else $error("read strobe lanes differ");
  a_first_beat: assert property ($rose(dqs_oe) |-> dqs_t_o == {LANES{1'b1}})
    else $error("first read strobe level wrong");
  a_drivers_off: assert property (power_state != 2'h0 |-> !dq_oe && !dqs_oe)
    else $error("driving while powered down");
  a_dpd_flag: assert property (deep_power_down == (power_state == 2'h3))
    else $error("deep power down flag wrong");
  a_dpd_reset: assert property ($fell(deep_power_down) |-> ##[0:2] burst_beat_count == 5'h04)
    else $error("settings kept after deep power down");
  a_cmd_gap: assert property (cmd_strobe |=> !cmd_strobe [*3])
    else $error("commands too close");
  a_ref_closed: assert property (refresh_pulse |-> bank_open == 4'h0)
    else $error("refresh with bank open");
  a_burst_legal: assert property (burst_beat_count inside {5'h04, 5'h08, 5'h10})
    else $error("illegal burst length");

  c_read: cover property ($rose(dq_oe));
  c_refresh: cover property (refresh_pulse);
  c_dpd_exit: cover property ($fell(deep_power_down));
endmodule // ddr_pin_checker

/* ctl_model.sv */
`timescale 1ns/10ps
module ctl_model #(
  parameter DQ_W  = 16,
  parameter LANES = DQ_W / 8
) (
  input  wire             clk,
  output reg              ck_t,
  output reg              ck_c,
  output reg              cke,
  output reg              cs_n,
  output reg  [9:0]       ca,
  output reg  [DQ_W-1:0]  dq_i,
  output reg  [LANES-1:0] dqs_t_i,
  output reg  [LANES-1:0] dqs_c_i,
  output reg  [LANES-1:0] dm_i
);
  initial begin
    ck_t = 1'b0;
    ck_c = 1'b1;
    cke = 1'b0;
    cs_n = 1'b1;
    ca = 10'h007;
    dq_i = {DQ_W{1'b0}};
    dqs_t_i = {LANES{1'b0}};
    dqs_c_i = {LANES{1'b1}};
    dm_i = {LANES{1'b0}};
  end

  // One link cycle; clock rests low between calls
  task automatic cyc(input k, input s, input [9:0] a1, input [9:0] a2);
    begin
      ck_t <= 1'b1;
      ck_c <= 1'b0;
      cke <= k;
      cs_n <= s;
      ca <= a1;
      repeat (4) @(posedge clk);
      ck_t <= 1'b0;
      ck_c <= 1'b1;
      ca <= a2;
      repeat (4) @(posedge clk);
    end
  endtask

  // Four beats, strobe toggled mid-bit on all lanes
  task automatic wr(input [4*DQ_W-1:0] d, input [4*LANES-1:0] m);
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        ck_t <= ~i[0];
        ck_c <= i[0];
        cs_n <= 1'b1;
        dq_i <= d[i*DQ_W +: DQ_W];
        dm_i <= m[i*LANES +: LANES];
        repeat (2) @(posedge clk);
        dqs_t_i <= ~dqs_t_i;
        dqs_c_i <= ~dqs_c_i;
        repeat (2) @(posedge clk);
      end
      dq_i <= ~dq_i;
      dm_i <= ~dm_i;
    end
  endtask
endmodule // ctl_model

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
  localparam [9:0]  NOP   = 10'h007;
  localparam [11:0] CODES = {3'h2, 3'h4, 3'h7, 3'h3};
  localparam [19:0] BEATS = {5'h04, 5'h10, 5'h08, 5'h08};
  reg         clk = 1'b0;
  reg         reset = 1'b1;
  wire        ck_t, ck_c, cke, cs_n, dq_oe, dqs_oe, deep_power_down, cmd_strobe, refresh_pulse;
  wire [9:0]  ca;
  wire [15:0] dq_i, dq_o;
  wire [1:0]  dqs_t_i, dqs_c_i, dqs_t_o, dqs_c_o, dm_i, power_state;
  wire [3:0]  bank_open, read_latency_cycles, write_latency_cycles, partial_array_self_refresh;
  wire [4:0]  burst_beat_count;
  integer     n_mismatch = 0, tests_run = 0, n_ref = 0, n_oe = 0, n_cmd = 0, c0 = 0;
  reg         oe_q = 1'b0;

  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (!reset) begin
      n_ref <= n_ref + refresh_pulse;
      n_cmd <= n_cmd + cmd_strobe;
      n_oe <= n_oe + (dq_oe & ~oe_q);
      oe_q <= dq_oe;
    end
  end

  ctl_model u_ctl (.clk, .ck_t, .ck_c, .cke, .cs_n, .ca, .dq_i, .dqs_t_i, .dqs_c_i, .dm_i);
  ddr_sdram_pin_interface uut (.clk, .reset, .ck_t, .ck_c, .cke, .cs_n, .ca, .dq_i, .dq_o,
    .dq_oe, .dqs_t_i, .dqs_c_i, .dqs_t_o, .dqs_c_o, .dqs_oe, .dm_i, .power_state,
    .deep_power_down, .bank_open, .read_latency_cycles, .write_latency_cycles,
    .burst_beat_count, .partial_array_self_refresh, .cmd_strobe, .refresh_pulse);

  task chk(input [31:0] seen, input [31:0] exp, input [8*12-1:0] nm);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %0s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask

  task final_report;
    begin
      if (n_mismatch == 0 && tests_run > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // Command cycle followed by one deselected cycle
  task cmd(input k, input s, input [9:0] a1, input [9:0] a2);
    begin
      u_ctl.cyc(k, s, a1, a2);
      u_ctl.cyc(k, 1'b1, NOP, NOP);
    end
  endtask

  task rd(input [63:0] e);
    integer i, n;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        n = 0;
        while (!(dq_oe === 1'b1 && dqs_t_o === {2{~i[0]}}) && n < 200) begin
          @(negedge clk);
          n = n + 1;
        end
        if (n >= 200) begin
          n_mismatch = n_mismatch + 1;
          final_report;
        end
        chk(dq_o, e[i*16 +: 16], "read beat");
      end
      repeat (12) @(negedge clk);
      chk(dq_oe, 1'b0, "burst end");
    end
  endtask

  task t_reset;
    begin
      chk({power_state, read_latency_cycles, write_latency_cycles}, 10'h031, "defaults");
      chk(burst_beat_count, 5'h04, "burst");
      chk({dq_oe, dqs_oe, dqs_c_o, bank_open}, 8'h30, "idle pins");
    end
  endtask

  task t_modes;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        cmd(1'b1, 1'b0, 10'h010, {7'h00, CODES[i*3 +: 3]});
        chk(burst_beat_count, BEATS[i*5 +: 5], "burst");
      end
      cmd(1'b1, 1'b0, 10'h020, 10'h024);
      cmd(1'b1, 1'b0, 10'h020, 10'h000);
      chk({write_latency_cycles, read_latency_cycles}, 8'h24, "latency");
      cmd(1'b1, 1'b0, 10'h020, 10'h013);
      cmd(1'b1, 1'b0, 10'h100, 10'h005);
      cmd(1'b1, 1'b0, 10'h110, 10'h00a);
      chk(partial_array_self_refresh, 4'h5, "bank mask");
    end
  endtask

  task t_banks;
    begin
      c0 = n_cmd;
      cmd(1'b1, 1'b1, 10'h002, 10'h001);
      chk(bank_open, 4'h0, "deselected");
      cmd(1'b1, 1'b0, 10'h002, 10'h001);
      cmd(1'b1, 1'b0, 10'h002, 10'h003);
      chk(bank_open, 4'ha, "activate");
      cmd(1'b1, 1'b0, 10'h00c, NOP);
      cmd(1'b1, 1'b0, 10'h00b, 10'h003);
      chk({n_ref[3:0], bank_open}, 8'h02, "pre one");
      cmd(1'b1, 1'b0, 10'h01b, NOP);
      cmd(1'b1, 1'b0, 10'h004, NOP);
      chk({n_ref[3:0], bank_open}, 8'h00, "pre all");
      cmd(1'b1, 1'b0, 10'h00c, NOP);
      chk(n_ref[3:0], 4'h1, "refresh");
      chk(n_cmd - c0, 32'h7, "cmd count");
    end
  endtask

  task t_data;
    begin
      cmd(1'b1, 1'b0, 10'h002, 10'h001);
      u_ctl.cyc(1'b1, 1'b0, 10'h001, 10'h011);
      u_ctl.wr(64'h1a2b_3c4d_5e6f_7081, 8'h00);
      u_ctl.cyc(1'b1, 1'b0, 10'h201, 10'h011);
      u_ctl.wr(64'hffff_eeee_dddd_cccc, 8'h24);
      u_ctl.cyc(1'b1, 1'b1, NOP, NOP);
      chk(bank_open, 4'h0, "auto close");
      u_ctl.cyc(1'b1, 1'b0, 10'h005, 10'h011);
      repeat (5) u_ctl.cyc(1'b1, 1'b1, NOP, NOP);
      chk(n_oe[3:0], 4'h0, "closed read");
      cmd(1'b1, 1'b0, 10'h002, 10'h001);
      fork
        begin
          u_ctl.cyc(1'b1, 1'b0, 10'h005, 10'h011);
          repeat (6) u_ctl.cyc(1'b1, 1'b1, NOP, NOP);
        end
        rd(64'hffff_3cee_dd6f_cccc);
      join
      @(posedge clk);
      chk(n_oe[3:0], 4'h1, "read count");
      cmd(1'b1, 1'b0, 10'h01b, NOP);
    end
  endtask

  task t_power;
    begin
      cmd(1'b0, 1'b1, NOP, NOP);
      cmd(1'b0, 1'b0, 10'h002, 10'h001);
      chk({power_state, bank_open}, 6'h10, "power down");
      cmd(1'b1, 1'b1, NOP, NOP);
      chk(power_state, 2'h0, "wake");
      u_ctl.cyc(1'b0, 1'b0, 10'h00c, NOP);
      repeat (40) @(posedge clk);
      chk(power_state, 2'h2, "self refresh");
      cmd(1'b1, 1'b1, NOP, NOP);
      cmd(1'b1, 1'b0, 10'h010, 10'h003);
      u_ctl.cyc(1'b0, 1'b0, 10'h003, NOP);
      chk({deep_power_down, power_state}, 3'h7, "deep down");
      cmd(1'b1, 1'b1, NOP, NOP);
      chk({burst_beat_count, partial_array_self_refresh, power_state}, 11'h100, "dpd exit");
    end
  endtask

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    t_reset;
    u_ctl.cyc(1'b1, 1'b1, NOP, NOP);
    t_modes;
    t_banks;
    t_data;
    t_power;
    final_report;
  end
endmodule // testbench

bind ddr_sdram_pin_interface ddr_pin_checker #(.DQ_W(DQ_W), .LANES(LANES)) u_chk (
  .clk(clk), .reset(reset), .dq_oe(dq_oe), .dqs_t_o(dqs_t_o), .dqs_c_o(dqs_c_o),
  .dqs_oe(dqs_oe), .power_state(power_state), .deep_power_down(deep_power_down),
  .bank_open(bank_open), .burst_beat_count(burst_beat_count), .cmd_strobe(cmd_strobe),
  .refresh_pulse(refresh_pulse));
